// file: include/guard_pkg.sv
// Shared constants, types and decode function for the sector write-protect logic.
package guard_pkg;

  // Array geometry: 64 MB of flash, 4 KB sectors in the bottom and top 64 KB.
  localparam int         ADDR_USED_W  = 26;
  localparam int         BLOCK_W      = 10;
  localparam int         BLOCK_LSB    = 16;
  localparam int         SECTOR_LSB   = 12;
  localparam int         SECTOR_W     = 4;
  localparam int         IDX_W        = 11;
  localparam int         EDGE_SECTORS = 16;
  localparam int         UNIT_COUNT   = 2 * EDGE_SECTORS + 1022;
  localparam logic [9:0] TOP_BLOCK    = 10'h3ff;

  // Serial framing counts, in serial clocks.
  localparam logic [5:0] OPC_CLKS_ONE  = 6'h08;
  localparam logic [5:0] OPC_CLKS_FOUR = 6'h02;
  localparam logic [5:0] ADR3_CLKS_ONE = 6'h18;
  localparam logic [5:0] ADR4_CLKS_ONE = 6'h20;
  localparam logic [5:0] ADR3_CLKS_FOUR = 6'h06;
  localparam logic [5:0] ADR4_CLKS_FOUR = 6'h08;

  // Output lanes: single-line answers leave on line 1, four-line on all lines.
  localparam logic [3:0] OE_ONE_LINE   = 4'h2;
  localparam logic [3:0] OE_FOUR_LINE  = 4'hf;
  localparam int         SO_LINE       = 1;
  localparam logic [2:0] FIRST_BIT_POS = 3'h7;

  // Lock register mode bits as presented on the two-bit mode input.
  localparam int LOCK_MODE_PWD_POS   = 1;
  localparam int LOCK_MODE_SOLID_POS = 0;

  // Instruction codes handled here.
  localparam logic [7:0] OP_NV_QUERY     = 8'he2;
  localparam logic [7:0] OP_NV_SET       = 8'he3;
  localparam logic [7:0] OP_NV_CLEAR_ALL = 8'he4;
  localparam logic [7:0] OP_VOL_QUERY    = 8'h3d;
  localparam logic [7:0] OP_VOL_SET      = 8'h36;
  localparam logic [7:0] OP_VOL_CLEAR    = 8'h39;
  localparam logic [7:0] OP_MASK_QUERY   = 8'haa;

  // Status bytes returned by guard queries.
  localparam logic [7:0] GUARD_OFF_BYTE = 8'h00;
  localparam logic [7:0] GUARD_ON_BYTE  = 8'hff;

  // Values after reset; NV_FACTORY is the value that factory init loads into the non-volatile bits.
  localparam logic       MASK_RESET = 1'b1;
  localparam logic       VOL_RESET  = 1'b1;
  localparam logic       NV_FACTORY = 1'b0;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_OPCODE = 3'b001,
    PH_ADDR   = 3'b010,
    PH_DUMMY  = 3'b011,
    PH_OUTPUT = 3'b100,
    PH_ARMED  = 3'b101,
    PH_IGNORE = 3'b110
  } phase_t;

  // Maps a byte address to its guard unit: sectors at both ends, blocks elsewhere.
  function automatic logic [IDX_W-1:0] unit_index(input logic [ADDR_USED_W-1:0] a);
    logic [BLOCK_W-1:0]  blk;
    logic [SECTOR_W-1:0] sec;
    blk = a[BLOCK_LSB +: BLOCK_W];
    sec = a[SECTOR_LSB +: SECTOR_W];
    if (blk == '0) begin
      unit_index = {7'h00, sec};
    end else if (blk == TOP_BLOCK) begin
      unit_index = IDX_W'(EDGE_SECTORS) + {7'h00, sec};
    end else begin
      unit_index = IDX_W'(2 * EDGE_SECTORS - 1) + {1'b0, blk};
    end
  endfunction

endpackage

// file: include/guard_if.sv
// Update and lookup signals between the command engine and the guard-bit store.
`timescale 1ns/1ps
`default_nettype none
interface guard_if;
  import guard_pkg::*;
  logic [IDX_W-1:0] upd_index;
  logic [IDX_W-1:0] rd_index;
  logic [IDX_W-1:0] chk_index;
  logic             set_nv;
  logic             clear_all_nv;
  logic             set_vol;
  logic             clr_vol;
  logic             nv_rd;
  logic             vol_rd;
  logic             nv_chk;
  logic             vol_chk;

  modport ctrl (output upd_index, rd_index, chk_index, set_nv, clear_all_nv, set_vol, clr_vol,
                input nv_rd, vol_rd, nv_chk, vol_chk);
  modport store (input upd_index, rd_index, chk_index, set_nv, clear_all_nv, set_vol, clr_vol,
                 output nv_rd, vol_rd, nv_chk, vol_chk);
endinterface
`default_nettype wire

// file: core/guard_store.sv
// Storage of the non-volatile and volatile guard bits with two read ports.
`timescale 1ns/1ps
`default_nettype none
module guard_store
  import guard_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic factory_init,
  guard_if.store    g
);

  typedef struct packed {
    logic [UNIT_COUNT-1:0] nv;
    logic [UNIT_COUNT-1:0] vol;
  } store_t;

  store_t s_q;
  store_t s_d;

  // Commands touch only the addressed unit, except the clear-all and factory init, which load every non-volatile bit.
  always_comb begin
    s_d = s_q;
    if (factory_init || g.clear_all_nv) begin
      s_d.nv = {UNIT_COUNT{NV_FACTORY}};
    end else if (g.set_nv) begin
      s_d.nv[g.upd_index] = 1'b1;
    end
    if (g.set_vol) begin
      s_d.vol[g.upd_index] = 1'b1;
    end else if (g.clr_vol) begin
      s_d.vol[g.upd_index] = 1'b0;
    end
  end

  // Reset leaves the non-volatile bits alone, as a power cycle would.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q.vol <= {UNIT_COUNT{VOL_RESET}};
      s_q.nv  <= s_d.nv;
    end else begin
      s_q <= s_d;
    end
  end

  // One bit per 4 KB edge sector or 64 KB block.
  assign g.nv_rd   = s_q.nv[g.rd_index];
  assign g.vol_rd  = s_q.vol[g.rd_index];
  assign g.nv_chk  = s_q.nv[g.chk_index];
  assign g.vol_chk = s_q.vol[g.chk_index];

endmodule // guard_store
`default_nettype wire

// file: core/sector_write_protect_bits.sv
// Serial command engine for sector and block write-protect guard bits.
`timescale 1ns/1ps
`default_nettype none
module sector_write_protect_bits
  import guard_pkg::*;
(
  input  wire logic                   CLOCK,
  input  wire logic                   RESETN,
  input  wire logic                   CS_N,
  input  wire logic                   SCLK,
  input  wire logic [3:0]             DATA_IN,
  output logic      [3:0]             DATA_OUT,
  output logic      [3:0]             DATA_OE,
  input  wire logic                   FOUR_LINE_COMMAND_MODE,
  input  wire logic                   ADDR_FOUR_BYTE,
  input  wire logic [3:0]             DUMMY_CLOCKS,
  input  wire logic [1:0]             LOCK_MODE_BITS,
  input  wire logic                   WRITE_LATCH_FLAG,
  output logic                        WRITE_LATCH_CLEAR,
  input  wire logic                   PASSWORD_UNLOCK_OK,
  input  wire logic                   GUARD_LOCK_CLEAR,
  input  wire logic                   GUARD_MASK_SET,
  input  wire logic                   GUARD_MASK_CLEAR,
  input  wire logic                   FACTORY_INIT,
  input  wire logic [ADDR_USED_W-1:0] CHECK_ADDR,
  output logic                        CHECK_PROTECTED,
  output logic                        GUARD_LOCK_FLAG,
  output logic                        GUARD_MASK_BIT
);

  typedef struct packed {
    logic       cs_s1;
    logic       cs_s2;
    logic       cs_s3;
    logic       sck_s1;
    logic       sck_s2;
    logic       sck_s3;
    logic [3:0] din_s1;
    logic [3:0] din_s2;
    phase_t     phase;
    logic [5:0] cnt;
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [2:0] out_pos;
    logic [3:0] dout;
    logic [3:0] oe;
    logic       lock;
    logic       pwd_ok;
    logic       mask;
    logic       set_nv;
    logic       clear_all_nv;
    logic       set_vol;
    logic       clr_vol;
    logic       latch_clr;
    logic       prot;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{
    cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
    phase: PH_IDLE, out_pos: FIRST_BIT_POS, mask: MASK_RESET,
    default: '0
  };

  guard_if g ();

  ctl_t q;
  ctl_t n;

  logic       quad;
  logic       pwd_mode;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic [5:0] opc_clks;
  logic [5:0] adr_clks;
  logic [7:0] opc_sh;
  logic [31:0] addr_sh;
  logic [7:0] ans_byte;
  logic       wl;
  logic       nv_ok;

  guard_store u_store (
    .clock        (CLOCK),
    .resetn       (RESETN),
    .factory_init (FACTORY_INIT),
    .g            (g.store)
  );

  // Mode decode and edge detection; edges compare the second and third synchroniser stages.
  always_comb begin
    quad     = FOUR_LINE_COMMAND_MODE;
    pwd_mode = ~LOCK_MODE_BITS[LOCK_MODE_PWD_POS] & LOCK_MODE_BITS[LOCK_MODE_SOLID_POS];
    sck_rise = q.sck_s2 & ~q.sck_s3;
    sck_fall = ~q.sck_s2 & q.sck_s3;
    cs_rise  = q.cs_s2 & ~q.cs_s3;
    opc_clks = quad ? OPC_CLKS_FOUR : OPC_CLKS_ONE;
    if (quad) begin
      adr_clks = ADDR_FOUR_BYTE ? ADR4_CLKS_FOUR : ADR3_CLKS_FOUR;
      opc_sh   = {q.opcode[3:0], q.din_s2};
      addr_sh  = {q.addr[27:0], q.din_s2};
    end else begin
      adr_clks = ADDR_FOUR_BYTE ? ADR4_CLKS_ONE : ADR3_CLKS_ONE;
      opc_sh   = {q.opcode[6:0], q.din_s2[0]};
      addr_sh  = {q.addr[30:0], q.din_s2[0]};
    end
    // The answer is rebuilt every cycle from the stored address, so it repeats freely.
    case (q.opcode)
      OP_NV_QUERY:   ans_byte = g.nv_rd ? GUARD_ON_BYTE : GUARD_OFF_BYTE;
      OP_VOL_QUERY:  ans_byte = g.vol_rd ? GUARD_ON_BYTE : GUARD_OFF_BYTE;
      OP_MASK_QUERY: ans_byte = {7'h00, q.mask};
      default:       ans_byte = GUARD_OFF_BYTE;
    endcase
    wl    = WRITE_LATCH_FLAG;
    nv_ok = wl & q.lock;
  end

  // Next-state logic for the whole engine.
  always_comb begin
    n              = q;
    n.cs_s1        = CS_N;
    n.cs_s2        = q.cs_s1;
    n.cs_s3        = q.cs_s2;
    n.sck_s1       = SCLK;
    n.sck_s2       = q.sck_s1;
    n.sck_s3       = q.sck_s2;
    n.din_s1       = DATA_IN;
    n.din_s2       = q.din_s1;
    n.set_nv       = 1'b0;
    n.clear_all_nv = 1'b0;
    n.set_vol      = 1'b0;
    n.clr_vol      = 1'b0;
    n.latch_clr    = 1'b0;

    if (q.cs_s2) begin
      // Writes take effect only on the closing edge of a complete frame.
      if (cs_rise && q.phase == PH_ARMED) begin
        case (q.opcode)
          OP_NV_SET: begin
            n.set_nv    = nv_ok;
            n.latch_clr = nv_ok;
          end
          OP_NV_CLEAR_ALL: begin
            n.clear_all_nv = nv_ok;
            n.latch_clr    = nv_ok;
          end
          OP_VOL_SET: begin
            n.set_vol   = wl;
            n.latch_clr = wl;
          end
          OP_VOL_CLEAR: begin
            n.clr_vol   = wl;
            n.latch_clr = wl;
          end
          default: begin
            n.latch_clr = 1'b0;
          end
        endcase
      end
      n.phase = PH_IDLE;
      n.cnt   = '0;
      n.oe    = '0;
      n.dout  = '0;
    end else begin
      case (q.phase)
        PH_IDLE: begin
          n.phase = PH_OPCODE;
          n.cnt   = '0;
          n.addr  = '0;  // A 3-byte address must not inherit the top bits of the last frame.
        end
        PH_OPCODE: begin
          if (sck_rise) begin
            n.opcode = opc_sh;
            n.cnt    = q.cnt + 6'h01;
            if (q.cnt + 6'h01 == opc_clks) begin
              n.cnt     = '0;
              n.out_pos = quad ? 3'h0 : FIRST_BIT_POS;
              case (opc_sh)
                OP_NV_QUERY, OP_VOL_QUERY, OP_NV_SET, OP_VOL_SET, OP_VOL_CLEAR: begin
                  n.phase = PH_ADDR;
                end
                OP_NV_CLEAR_ALL: n.phase = PH_ARMED;
                OP_MASK_QUERY:   n.phase = PH_OUTPUT;
                default:         n.phase = PH_IGNORE;
              endcase
            end
          end
        end
        PH_ADDR: begin
          if (sck_rise) begin
            n.addr = addr_sh;
            n.cnt  = q.cnt + 6'h01;
            if (q.cnt + 6'h01 == adr_clks) begin
              n.cnt = '0;
              if (q.opcode == OP_NV_QUERY && quad && DUMMY_CLOCKS != 4'h0) begin
                n.phase = PH_DUMMY;
              end else if (q.opcode == OP_NV_QUERY || q.opcode == OP_VOL_QUERY) begin
                n.phase = PH_OUTPUT;
              end else begin
                n.phase = PH_ARMED;
              end
            end
          end
        end
        PH_DUMMY: begin
          if (sck_rise) begin
            n.cnt = q.cnt + 6'h01;
            if (q.cnt + 6'h01 == {2'b00, DUMMY_CLOCKS}) begin
              n.cnt   = '0;
              n.phase = PH_OUTPUT;
            end
          end
        end
        PH_OUTPUT: begin
          // Each falling edge presents the next bit or nibble; wraps to repeat the byte.
          if (sck_fall) begin
            if (quad) begin
              n.dout    = q.out_pos[0] ? ans_byte[3:0] : ans_byte[7:4];
              n.oe      = OE_FOUR_LINE;
              n.out_pos = q.out_pos ^ 3'h1;
            end else begin
              n.dout          = '0;
              n.dout[SO_LINE] = ans_byte[q.out_pos];
              n.oe            = OE_ONE_LINE;
              n.out_pos       = q.out_pos - 3'h1;
            end
          end
        end
        PH_ARMED, PH_IGNORE: begin
          n.phase = q.phase;
        end
        default: begin
          n.phase = PH_IGNORE;
        end
      endcase
    end

    // A correct password wins over a lock-clear arriving in the same cycle.
    if (PASSWORD_UNLOCK_OK) begin
      n.lock   = 1'b1;
      n.pwd_ok = 1'b1;
    end else if (GUARD_LOCK_CLEAR) begin
      n.lock = 1'b0;
    end

    // The mask moves freely in fixed mode, only after a password otherwise.
    if ((GUARD_MASK_SET || GUARD_MASK_CLEAR) && (!pwd_mode || q.pwd_ok)) begin
      n.mask = GUARD_MASK_SET;
    end

    // A masked non-volatile guard no longer counts; either live guard blocks.
    n.prot = g.vol_chk | (g.nv_chk & q.mask);
  end

  // All state registered together; the lock flag's reset follows the mode bits.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      q      <= CTL_RESET;
      q.lock <= ~pwd_mode;
    end else begin
      q <= n;
    end
  end

  // Store hookup; the address holds after chip select rises, so updates see it.
  assign g.upd_index    = unit_index(q.addr[ADDR_USED_W-1:0]);
  assign g.rd_index     = unit_index(q.addr[ADDR_USED_W-1:0]);
  assign g.chk_index    = unit_index(CHECK_ADDR);
  assign g.set_nv       = q.set_nv;
  assign g.clear_all_nv = q.clear_all_nv;
  assign g.set_vol      = q.set_vol;
  assign g.clr_vol      = q.clr_vol;

  assign DATA_OUT          = q.dout;
  assign DATA_OE           = q.oe;
  assign WRITE_LATCH_CLEAR = q.latch_clr;
  assign CHECK_PROTECTED   = q.prot;
  assign GUARD_LOCK_FLAG   = q.lock;
  assign GUARD_MASK_BIT    = q.mask;

endmodule // sector_write_protect_bits
`default_nettype wire

// file: bench/host_model.sv
// Behavioural host controller that frames guard instructions on the serial link.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clock,
  input  wire logic       four,
  input  wire logic [3:0] io,
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      drv
);
  // Link idles with chip select high and the serial clock low.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    drv  = 4'h5;
  end

  // Half a serial clock is four system clocks, so the link runs at 64 ns.
  task automatic half();
    repeat (4) @(posedge clock);
  endtask

  // Sends n bits MSB first, one bit or one nibble per serial clock.
  task automatic send(input logic [31:0] v, input int n);
    for (int i = n; i > 0; i -= (four ? 4 : 1)) begin
      drv <= four ? 4'(v >> (i - 4)) : {3'h0, v[i-1]};
      half();
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
  endtask

  // Reads n units; idle lines toggle so a stale level cannot pass for an answer.
  task automatic recv(input int n, output logic [15:0] rd);
    rd = 16'h0;
    for (int i = 0; i < n; i++) begin
      drv <= ~drv;
      half();
      sclk <= 1'b1;
      half();
      rd = four ? {rd[11:0], io} : {rd[14:0], io[1]};
      sclk <= 1'b0;
    end
  endtask

  // One whole frame: opcode, optional address and dummy clocks, then the answer.
  task automatic frame(input logic [7:0] op, input int abits, input logic [31:0] adr,
                       input int dum, input int n, output logic [15:0] rd);
    cs_n <= 1'b0;
    half();
    send({24'h0, op}, 8);
    if (abits > 0) send(adr, abits);
    if (dum > 0) send(32'h0, 4 * dum);
    recv(n, rd);
    half();
    cs_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
endmodule // host_model
`default_nettype wire

// file: bench/sector_write_protect_bits_sva.sv
// Concurrent checks on the ports of the guard command engine.
`timescale 1ns/1ps
`default_nettype none
module wp_checker
  import guard_pkg::*;
(
  input wire logic       CLOCK,
  input wire logic       RESETN,
  input wire logic       CS_N,
  input wire logic [3:0] DATA_OE,
  input wire logic       FOUR_LINE_COMMAND_MODE,
  input wire logic [1:0] LOCK_MODE_BITS,
  input wire logic       WRITE_LATCH_FLAG,
  input wire logic       WRITE_LATCH_CLEAR,
  input wire logic       PASSWORD_UNLOCK_OK,
  input wire logic       GUARD_MASK_SET,
  input wire logic       GUARD_LOCK_FLAG,
  input wire logic       GUARD_MASK_BIT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  // A frame ends on a rising chip select, after which the lanes must be let go.
  sequence s_frame_end;
    $rose(CS_N);
  endsequence
  sequence s_released;
    ##[1:5] (DATA_OE == 4'h0);
  endsequence

  AST_OE_RELEASE: assert property (s_frame_end |-> s_released)
    else $error("lanes still driven after chip select rose");
  AST_OE_LANES: assert property ((DATA_OE != 4'h0) |->
    DATA_OE == (FOUR_LINE_COMMAND_MODE ? OE_FOUR_LINE : OE_ONE_LINE))
    else $error("answer on wrong lanes");
  AST_LATCH_ONE: assert property (WRITE_LATCH_CLEAR |=> !WRITE_LATCH_CLEAR)
    else $error("latch clear longer than one cycle");
  AST_LATCH_COND: assert property (WRITE_LATCH_CLEAR |->
    $past(WRITE_LATCH_FLAG) && CS_N)
    else $error("guard write executed without latch or inside frame");
  AST_MASK_RST: assert property (disable iff (1'b0)
    !RESETN |=> GUARD_MASK_BIT == MASK_RESET)
    else $error("mask bit not set by reset");
  AST_LOCK_RST: assert property (disable iff (1'b0)
    !RESETN |=> GUARD_LOCK_FLAG == ($past(LOCK_MODE_BITS) != 2'b01))
    else $error("lock flag reset value wrong for mode");
  AST_OUT_RST: assert property (disable iff (1'b0)
    !RESETN |=> DATA_OE == 4'h0 && !WRITE_LATCH_CLEAR)
    else $error("outputs active during reset");
  AST_UNLOCK: assert property (PASSWORD_UNLOCK_OK |=> GUARD_LOCK_FLAG)
    else $error("password unlock did not set lock flag");
  AST_MASK_SET: assert property (GUARD_MASK_SET && LOCK_MODE_BITS != 2'b01
    |=> GUARD_MASK_BIT)
    else $error("mask set ignored in fixed mode");
endmodule // wp_checker
bind sector_write_protect_bits wp_checker u_wp_checker (.CLOCK, .RESETN, .CS_N, .DATA_OE,
  .FOUR_LINE_COMMAND_MODE, .LOCK_MODE_BITS, .WRITE_LATCH_FLAG, .WRITE_LATCH_CLEAR,
  .PASSWORD_UNLOCK_OK, .GUARD_MASK_SET, .GUARD_LOCK_FLAG, .GUARD_MASK_BIT);
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the sector write-protect command engine.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import guard_pkg::*;
  `define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
  logic clock = 1'b0, resetn = 1'b0, four = 1'b0, abyte4 = 1'b0, latch = 1'b0;
  // One-cycle control pulses share a vector so that a single task can raise any of them.
  localparam logic [4:0] unlock = 5'h01, lock_clr = 5'h02, mask_set = 5'h04, mask_clr = 5'h08;
  localparam logic [4:0] factory = 5'h10;
  logic [4:0]             pls = 5'h00;
  logic [3:0]             dummy = 4'h0;
  logic [1:0]             lock_mode = 2'b11;
  logic [ADDR_USED_W-1:0] chk_addr = '0;
  logic [15:0]            rd;
  logic [3:0]             drv, io, data_out, data_oe;
  logic                   cs_n, sclk, wl_clr, prot, lock_flag, mask_bit;
  int                     num_errors = 0, compares = 0, abits = 24, latch_clears = 0;

  // Each shared line carries whoever enables it, else the host's level.
  assign io = (data_oe & data_out) | (~data_oe & drv);

  // Counts executed guard writes; sampled mid-cycle, away from the launching edge.
  always @(negedge clock) if (wl_clr === 1'b1) latch_clears++;

  // System clock at 125 MHz.
  initial forever #4 clock = ~clock;

  host_model u_host_model (.clock(clock), .four(four), .io(io), .cs_n(cs_n), .sclk(sclk),
    .drv(drv));
  sector_write_protect_bits u_sector_write_protect_bits (.CLOCK(clock), .RESETN(resetn),
    .CS_N(cs_n), .SCLK(sclk), .DATA_IN(io), .DATA_OUT(data_out), .DATA_OE(data_oe),
    .FOUR_LINE_COMMAND_MODE(four), .ADDR_FOUR_BYTE(abyte4), .DUMMY_CLOCKS(dummy),
    .LOCK_MODE_BITS(lock_mode), .WRITE_LATCH_FLAG(latch), .WRITE_LATCH_CLEAR(wl_clr),
    .PASSWORD_UNLOCK_OK(pls[0]), .GUARD_LOCK_CLEAR(pls[1]), .GUARD_MASK_SET(pls[2]),
    .GUARD_MASK_CLEAR(pls[3]), .FACTORY_INIT(pls[4]), .CHECK_ADDR(chk_addr),
    .CHECK_PROTECTED(prot), .GUARD_LOCK_FLAG(lock_flag), .GUARD_MASK_BIT(mask_bit));

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic rst(input logic [1:0] m);
    lock_mode <= m;
    resetn <= 1'b0;
    cyc(8);
    resetn <= 1'b1;
    cyc(4);
  endtask
  // Raises the selected control pulse for a single cycle.
  task automatic pulse(input logic [4:0] m);
    pls <= m;
    cyc(1);
    pls <= 5'h00;
    cyc(3);
  endtask
  // Queries read two whole status bytes, so the repeat of the byte is seen too.
  task automatic q(input logic [7:0] op, input logic [31:0] a, input int d);
    u_host_model.frame(op, abits, a, d, four ? 4 : 16, rd);
  endtask
  task automatic w(input logic [7:0] op, input logic [31:0] a);
    u_host_model.frame(op, abits, a, 0, 0, rd);
  endtask
  task automatic prot_is(input logic [31:0] a, input logic e);
    chk_addr <= a[ADDR_USED_W-1:0];
    cyc(3);
    `CHK(prot, e)
  endtask

  task automatic t_reset_state();
    `CHK(mask_bit, MASK_RESET)
    `CHK(lock_flag, 1'b1)
    q(OP_VOL_QUERY, 32'h0, 0);
    `CHK(rd, {2{GUARD_ON_BYTE}})
    q(OP_NV_QUERY, 32'h3ff_f000, 0);
    `CHK(rd, {2{GUARD_OFF_BYTE}})
    u_host_model.frame(OP_MASK_QUERY, 0, 0, 0, 8, rd);
    `CHK(rd[7:0], 8'h01)
  endtask

  task automatic t_write();
    latch <= 1'b1;
    w(OP_VOL_CLEAR, 32'h1000);
    q(OP_VOL_QUERY, 32'h1000, 0);
    `CHK(rd, 16'h0000)
    q(OP_VOL_QUERY, 32'h2000, 0);
    `CHK(rd, 16'hffff)
    prot_is(32'h1fff, 1'b0);
    w(OP_NV_SET, 32'h1000);
    q(OP_NV_QUERY, 32'h1abc, 0);
    `CHK(rd, 16'hffff)
    q(OP_NV_QUERY, 32'h0, 0);
    `CHK(rd, 16'h0000)
    prot_is(32'h1000, 1'b1);
    pulse(mask_clr);
    prot_is(32'h1000, 1'b0);
    pulse(mask_set);
    w(OP_VOL_SET, 32'h1000);
    q(OP_VOL_QUERY, 32'h1000, 0);
    `CHK(rd, 16'hffff)
    u_host_model.frame(OP_NV_CLEAR_ALL, 0, 0, 0, 0, rd);
    q(OP_NV_QUERY, 32'h1000, 0);
    `CHK(rd, 16'h0000)
    `CHK(latch_clears, 4)
  endtask

  task automatic t_refuse();
    latch <= 1'b0;
    w(OP_NV_SET, 32'h5_0000);
    q(OP_NV_QUERY, 32'h5_0000, 0);
    `CHK(rd, 16'h0000)
    latch <= 1'b1;
    pulse(lock_clr);
    `CHK(lock_flag, 1'b0)
    w(OP_NV_SET, 32'h5_0000);
    q(OP_NV_QUERY, 32'h5_0000, 0);
    `CHK(rd, 16'h0000)
    `CHK(latch_clears, 4)
    pulse(unlock);
    `CHK(lock_flag, 1'b1)
    w(OP_NV_SET, 32'h5_0000);
    q(OP_NV_QUERY, 32'h5_0000, 0);
    `CHK(rd, 16'hffff)
    `CHK(latch_clears, 5)
  endtask

  // Four-line framing with four- then three-byte addresses, then a single-line four-byte query; mode only changes between frames.
  task automatic t_four();
    four <= 1'b1;
    abyte4 <= 1'b1;
    dummy <= 4'h3;
    abits = 32;
    cyc(4);
    q(OP_NV_QUERY, 32'h0005_8000, 3);
    `CHK(rd, 16'hffff)
    q(OP_VOL_QUERY, 32'h0005_0000, 0);
    `CHK(rd, 16'hffff)
    w(OP_VOL_CLEAR, 32'h03ff_0000);
    q(OP_VOL_QUERY, 32'h03ff_0fff, 0);
    `CHK(rd, 16'h0000)
    q(OP_VOL_QUERY, 32'h03ff_1000, 0);
    `CHK(rd, 16'hffff)
    u_host_model.frame(OP_MASK_QUERY, 0, 0, 0, 2, rd);
    `CHK(rd[7:0], 8'h01)
    abyte4 <= 1'b0;
    abits = 24;
    cyc(4);
    w(OP_VOL_CLEAR, 32'h0000_3000);
    q(OP_VOL_QUERY, 32'h0000_3000, 0);
    `CHK(rd, 16'h0000)
    four <= 1'b0;
    abyte4 <= 1'b1;
    abits = 32;
    cyc(4);
    q(OP_VOL_QUERY, 32'h03ff_0000, 0);
    `CHK(rd, 16'h0000)
    abyte4 <= 1'b0;
    abits = 24;
    cyc(4);
  endtask

  task automatic t_pwd();
    rst(2'b01);
    `CHK(lock_flag, 1'b0)
    pulse(mask_clr);
    `CHK(mask_bit, 1'b1)
    pulse(unlock);
    pulse(mask_clr);
    `CHK(mask_bit, 1'b0)
    q(OP_NV_QUERY, 32'h5_0000, 0);
    `CHK(rd, 16'hffff)
  endtask

  task automatic results();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Main sequence; the non-volatile store gets its factory state once.
  initial begin
    rst(2'b11);
    pulse(factory);
    t_reset_state();
    t_write();
    t_refuse();
    t_four();
    t_pwd();
    results();
  end

  // Watchdog sized well above the roughly 8100 cycles the scenarios need.
  initial begin
    cyc(40000);
    num_errors++;
    results();
  end
endmodule // tb_top
`default_nettype wire
